/* core/masc_top.sv */
// Register file, channel sequencer and output control of the monitor device.
// Assumes the serial port hands over whole register accesses on clk_i and
// that the converter core answers each start with one done pulse.
`timescale 1ns/1ps

// Function
// - Include bits 14,13,11,10,8,7,6,5 select channels 0 to 7.
// - Range bits 15..8 pick double or single reference; reset 0xFF00.
// - Force-clear bit drives its output to the preset value until cleared.
// - Update-mode bit: 1 synchronous, 0 immediate; reset zero.
// - Commit bit loads synchronous outputs written since previous commit.
// - Bit 14 powers the converter, reset 0 meaning power-down.
// - Bit 13 selects internal buffered reference or external reference.
// - Bits 12..9 power outputs 0..3; off means high impedance.
// - Writing key 0x6600 to reset register starts full device reset.
// - Serial transactions are ignored while the soft reset runs.
// - Identity register returns fixed part code and ignores writes.
// - Trigger aborts conversion, restarts at first enabled channel.
// - Trigger bit self-clears once the requested cycle has started.
// - Mode bit 13: 1 auto, 0 direct; auto after reset.
// - Direct mode converts each enabled channel once then idles.
// - Auto mode repeats the enabled sequence continuously.
// - Trigger, mode change or channel-select rewrite stops running cycle.
// - Trigger together with mode 0 to 1 stops and waits for trigger.
// - Results are held, then all move to readable registers at cycle end.
// - Direct mode ready flag and pin set at end; result read or trigger clears.
module masc_top
  import masc_pkg::*;
(
  input  wire logic                         clk_i,          // 25 MHz clock
  input  wire logic                         rstn_i,         // Async reset
  input  wire logic                         reg_wr_i,       // Write strobe
  input  wire logic                         reg_rd_i,       // Read strobe
  input  wire logic [masc_pkg::ADDR_W-1:0]  reg_addr_i,     // Register
  input  wire logic [15:0]                  reg_wdata_i,    // Write word
  output logic      [15:0]                  reg_rdata_o,    // Read word
  output logic                              reg_rvalid_o,   // Read done
  output logic                              conv_start_o,   // Start pulse
  output logic                              conv_abort_o,   // Abort pulse
  output logic      [2:0]                   conv_chan_o,    // Input select
  output logic                              conv_range_o,   // 1: 2x ref
  input  wire logic                         conv_done_i,    // Result pulse
  input  wire logic [masc_pkg::RES_W-1:0]   conv_data_i,    // Result
  output logic                              adc_power_o,    // Converter on
  output logic                              ref_buf_on_o,   // Int. ref
  output logic      [3:0]                   dac_on_o,       // Output on
  output logic      [3:0][masc_pkg::RES_W-1:0] dac_code_o,  // Output codes
  output logic      [3:0]                   dac_sync_o,     // Sync mode
  output logic                              result_ready_pin_o,    // Low
  output logic                              result_ready_pin_oe_o, // Drive
  output logic                              srst_busy_o     // Soft reset
);
  import masc_pkg::*;

  typedef struct packed {
    logic [15:0]                chan_sel;
    logic [15:0]                range_sel;
    logic [3:0]                 fclr;
    logic [3:0]                 umode;
    logic                       adc_on;
    logic                       ref_on;
    logic [3:0]                 dac_on;
    logic                       mode;
    logic                       trig;
    logic [1:0]                 rate;
    logic                       ready;
    logic [15:0]                key;
    logic [3:0][RES_W-1:0]      dac_data;
    logic [3:0][RES_W-1:0]      clr_val;
    logic [3:0][RES_W-1:0]      latch;
    logic [3:0]                 dirty;
    logic [3:0][RES_W-1:0]      dac_out;
    logic [7:0][RES_W-1:0]      tmp;
    logic [7:0][RES_W-1:0]      result;
    masc_seq_e                  seq;
    logic [2:0]                 chan;
    logic                       conv_start;
    logic                       conv_abort;
    logic                       conv_range;
    logic [4:0]                 pulse;
    logic                       pin_low;
    logic [9:0]                 srst;
    logic                       srst_busy;
    logic [15:0]                rdata;
    logic                       rvalid;
  } masc_state_s;

  localparam masc_state_s RST_S = '{range_sel: RANGE_RST, mode: 1'b1,
                                    seq: SEQ_IDLE, default: '0};

  masc_state_s q;
  masc_state_s d;
  logic [7:0]  en;
  logic        found;
  logic [2:0]  nxt;
  logic        wr_cfg;
  logic        trig_wr;
  logic        mode_up;
  logic        stop;
  logic [6:0]  idx;

  // Lowest enabled channel at or above the start index.
  function automatic logic [3:0] first_from(input logic [7:0] e,
                                            input logic [3:0] s);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 7; i >= 0; i--) begin
      if (e[i] && (4'(i) >= s)) begin
        r = {1'b1, 3'(i)};
      end
    end
    return r;
  endfunction

  always_comb begin
    d = q;
    d.rvalid = 1'b0;
    d.conv_start = 1'b0;
    d.conv_abort = 1'b0;
    found = 1'b0;
    nxt = 3'h0;
    idx = 7'h0;
    for (int i = 0; i < 8; i++) begin
      en[i] = q.chan_sel[CHAN_POS[i]];
    end
    wr_cfg = reg_wr_i && (reg_addr_i == A_CONFIG);
    trig_wr = wr_cfg && reg_wdata_i[CFG_TRIG];
    mode_up = wr_cfg && !q.mode && reg_wdata_i[CFG_MODE];
    stop = trig_wr || (wr_cfg && (reg_wdata_i[CFG_MODE] != q.mode)) ||
           (reg_wr_i && (reg_addr_i == A_CHAN_SEL));
    if (q.srst != 10'h0) begin
      // Everything returns to defaults; port accesses are dropped.
      d = RST_S;
      d.srst = q.srst - 10'h1;
    end else if (reg_wr_i && (reg_addr_i == A_SRST_KEY) &&
                 (reg_wdata_i == SRST_KEY)) begin
      d = RST_S;
      d.conv_abort = (q.seq == SEQ_BUSY);
      d.srst = 10'(SRST_CYC);
    end else begin
      if (reg_wr_i) begin
        idx = reg_addr_i;
        case (reg_addr_i)
          A_CONFIG: begin
            d.mode = reg_wdata_i[CFG_MODE];
            d.rate = reg_wdata_i[CFG_RATE+:2];
            if (reg_wdata_i[CFG_LOAD]) begin
              for (int i = 0; i < 4; i++) begin
                if (q.umode[i] && q.dirty[i]) begin
                  d.latch[i] = q.dac_data[i];
                  d.dirty[i] = 1'b0;
                end
              end
            end
          end
          A_CHAN_SEL:  d.chan_sel = reg_wdata_i & CHAN_MASK;
          A_RANGE_SEL: d.range_sel = reg_wdata_i & RANGE_RST;
          A_FORCE_CLR: d.fclr = reg_wdata_i[3:0];
          A_UPD_MODE:  d.umode = reg_wdata_i[3:0];
          A_POWER: begin
            d.adc_on = reg_wdata_i[PWR_ADC];
            d.ref_on = reg_wdata_i[PWR_REF];
            for (int i = 0; i < 4; i++) begin
              d.dac_on[i] = reg_wdata_i[PWR_DAC0-i];
            end
          end
          A_SRST_KEY:  d.key = reg_wdata_i;
          default: begin
            if ((idx >= A_DACDATA0) && (idx <= A_DACDATA3)) begin
              d.dac_data[2'(idx - A_DACDATA0)] = reg_wdata_i[RES_W-1:0];
              if (q.umode[2'(idx - A_DACDATA0)]) begin
                d.dirty[2'(idx - A_DACDATA0)] = 1'b1;
              end else begin
                d.latch[2'(idx - A_DACDATA0)] = reg_wdata_i[RES_W-1:0];
              end
            end else if ((idx >= A_DACCLR0) && (idx <= A_DACCLR3)) begin
              d.clr_val[2'(idx - A_DACCLR0)] = reg_wdata_i[RES_W-1:0];
            end
          end
        endcase
      end
      if (reg_rd_i) begin
        idx = reg_addr_i;
        d.rvalid = 1'b1;
        d.rdata = 16'h0000;
        case (reg_addr_i)
          A_CONFIG: begin
            d.rdata[CFG_MODE] = q.mode;
            d.rdata[CFG_TRIG] = q.trig;
            d.rdata[CFG_RATE+:2] = q.rate;
            d.rdata[CFG_READY] = q.ready;
          end
          A_CHAN_SEL:  d.rdata = q.chan_sel;
          A_RANGE_SEL: d.rdata = q.range_sel;
          A_FORCE_CLR: d.rdata[3:0] = q.fclr;
          A_UPD_MODE:  d.rdata[3:0] = q.umode;
          A_POWER: begin
            d.rdata[PWR_ADC] = q.adc_on;
            d.rdata[PWR_REF] = q.ref_on;
            for (int i = 0; i < 4; i++) begin
              d.rdata[PWR_DAC0-i] = q.dac_on[i];
            end
          end
          A_SRST_KEY:  d.rdata = q.key;
          A_IDENTITY:  d.rdata = PART_CODE;
          default: begin
            if ((idx >= A_RESULT0) && (idx <= A_RESULT7)) begin
              d.rdata[RES_W-1:0] = q.result[3'(idx - A_RESULT0)];
              d.ready = 1'b0;
            end else if ((idx >= A_DACDATA0) && (idx <= A_DACDATA3)) begin
              d.rdata[RES_W-1:0] = q.dac_data[2'(idx - A_DACDATA0)];
            end else if ((idx >= A_DACCLR0) && (idx <= A_DACCLR3)) begin
              d.rdata[RES_W-1:0] = q.clr_val[2'(idx - A_DACCLR0)];
            end
          end
        endcase
      end
      if (trig_wr || (wr_cfg && (reg_wdata_i[CFG_MODE] != q.mode))) begin
        d.ready = 1'b0;
      end
      if (q.pulse != 5'h0) begin
        d.pulse = q.pulse - 5'h1;
      end
      case (q.seq)
        SEQ_IDLE: begin
          if (q.trig && q.adc_on) begin
            {found, nxt} = first_from(en, 4'h0);
            d.trig = 1'b0;
            if (found) begin
              d.chan = nxt;
              d.conv_start = 1'b1;
              d.seq = SEQ_BUSY;
            end
          end
        end
        SEQ_BUSY: begin
          if (conv_done_i) begin
            d.tmp[q.chan] = conv_data_i;
            {found, nxt} = first_from(en, {1'b0, q.chan} + 4'h1);
            if (found) begin
              d.chan = nxt;
              d.conv_start = 1'b1;
            end else begin
              d.result = d.tmp;
              if (q.mode) begin
                {found, nxt} = first_from(en, 4'h0);
                d.chan = nxt;
                d.conv_start = found;
                d.seq = found ? SEQ_BUSY : SEQ_IDLE;
                d.pulse = 5'(PULSE_CYC);
              end else begin
                d.ready = 1'b1;
                d.seq = SEQ_IDLE;
              end
            end
          end
        end
        default: d.seq = SEQ_IDLE;
      endcase
      if (stop) begin
        d.conv_abort = (q.seq == SEQ_BUSY);
        d.conv_start = 1'b0;
        d.seq = SEQ_IDLE;
        d.trig = trig_wr && !mode_up;
      end
      if (!q.adc_on && (q.seq == SEQ_BUSY)) begin
        d.conv_abort = 1'b1;
        d.conv_start = 1'b0;
        d.seq = SEQ_IDLE;
      end
      d.conv_range = d.range_sel[RANGE_CH0 - 32'(d.chan)];
    end
    for (int i = 0; i < 4; i++) begin
      d.dac_out[i] = d.fclr[i] ? d.clr_val[i] : d.latch[i];
    end
    d.pin_low = d.ready || (d.pulse != 5'h0);
    d.srst_busy = (d.srst != 10'h0);
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q <= RST_S;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata_o = q.rdata;
  assign reg_rvalid_o = q.rvalid;
  assign conv_start_o = q.conv_start;
  assign conv_abort_o = q.conv_abort;
  assign conv_chan_o = q.chan;
  assign conv_range_o = q.conv_range;
  assign adc_power_o = q.adc_on;
  assign ref_buf_on_o = q.ref_on;
  assign dac_on_o = q.dac_on;
  assign dac_code_o = q.dac_out;
  assign dac_sync_o = q.umode;
  assign result_ready_pin_o = 1'b0;
  assign result_ready_pin_oe_o = q.pin_low;
  assign srst_busy_o = q.srst_busy;
endmodule

/* include/masc_pkg.sv */
// Constants and types shared by the monitor converter sequencer control.
// Assumes register words arrive already deframed from the serial port.
package masc_pkg;
  localparam int          RES_W        = 10;
  localparam int          ADDR_W       = 7;
  // Register addresses.
  localparam logic [6:0]  A_CONFIG     = 7'h36;
  localparam logic [6:0]  A_CHAN_SEL   = 7'h37;
  localparam logic [6:0]  A_RANGE_SEL  = 7'h38;
  localparam logic [6:0]  A_FORCE_CLR  = 7'h39;
  localparam logic [6:0]  A_UPD_MODE   = 7'h3A;
  localparam logic [6:0]  A_POWER      = 7'h3B;
  localparam logic [6:0]  A_SRST_KEY   = 7'h3E;
  localparam logic [6:0]  A_IDENTITY   = 7'h40;
  localparam logic [6:0]  A_RESULT0    = 7'h23;
  localparam logic [6:0]  A_RESULT7    = 7'h2A;
  localparam logic [6:0]  A_DACDATA0   = 7'h2B;
  localparam logic [6:0]  A_DACDATA3   = 7'h2E;
  localparam logic [6:0]  A_DACCLR0    = 7'h2F;
  localparam logic [6:0]  A_DACCLR3    = 7'h32;
  // Reset values, key and channel mask.
  localparam logic [15:0] RANGE_RST    = 16'hFF00;
  localparam logic [15:0] SRST_KEY     = 16'h6600;
  localparam logic [15:0] CHAN_MASK    = 16'h6DE0;
  // Arbitrary neutral identity value.
  localparam logic [15:0] PART_CODE    = 16'h5A01;
  // Field positions.
  localparam int          CFG_MODE     = 13;
  localparam int          CFG_TRIG     = 12;
  localparam int          CFG_LOAD     = 11;
  localparam int          CFG_RATE     = 8;
  localparam int          CFG_READY    = 7;
  localparam int          PWR_ADC      = 14;
  localparam int          PWR_REF      = 13;
  localparam int          PWR_DAC0     = 12;
  localparam int          RANGE_CH0    = 15;
  // Channel-include bit of channels 7 down to 0.
  localparam logic [7:0][3:0] CHAN_POS = {4'h5, 4'h6, 4'h7, 4'h8,
                                          4'hA, 4'hB, 4'hD, 4'hE};
  // Timing.
  localparam int          CLK_MHZ      = 25;
  localparam int          SRST_US      = 30;
  localparam int          SRST_CYC     = SRST_US * CLK_MHZ;
  localparam int          PULSE_US     = 1;
  localparam int          PULSE_CYC    = PULSE_US * CLK_MHZ;

  typedef enum logic [0:0] {
    SEQ_IDLE = 1'b0,
    SEQ_BUSY = 1'b1
  } masc_seq_e;
endpackage

/* testbench/masc_conv_model.sv */
// Behavioural converter: answers each start with one done after lat_i cycles.
// Assumes lat_i is at least 2; result holds the input number in bits 9:7.
`timescale 1ns/1ps
module masc_conv_model (
  input  wire logic       clk_i,   // Clock
  input  wire logic       rstn_i,  // Async reset
  input  wire logic       start_i, // Start pulse
  input  wire logic       abort_i, // Abort pulse
  input  wire logic [2:0] chan_i,  // Input select
  input  wire logic [3:0] lat_i,   // Answer delay
  output logic            done_o,  // Result pulse
  output logic [9:0]      data_o   // Result
);
  logic [3:0] cnt_q;
  logic [2:0] ch_q;
  // Data toggles outside the done pulse so a stale sample cannot pass.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_q  <= 4'h0;
      ch_q   <= 3'h0;
      done_o <= 1'b0;
      data_o <= 10'h000;
    end else begin
      done_o <= !start_i && !abort_i && cnt_q == 4'h1;
      data_o <= (cnt_q == 4'h1) ? {ch_q, 7'h55} : ~data_o;
      if (start_i) begin
        cnt_q <= lat_i;
        ch_q  <= chan_i;
      end else if (abort_i) begin
        cnt_q <= 4'h0;
      end else if (cnt_q != 4'h0) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
endmodule

/* testbench/masc_props.sv */
// Port checker of the sequencer control: registers, soft reset, converter.
// Assumes it is bound to masc_top and sees only that module's ports.
`timescale 1ns/1ps
module masc_props
  import masc_pkg::*;
(
  input wire logic              clk_i,                 // Clock
  input wire logic              rstn_i,                // Async reset
  input wire logic              reg_wr_i,              // Write strobe
  input wire logic              reg_rd_i,              // Read strobe
  input wire logic [ADDR_W-1:0] reg_addr_i,            // Register
  input wire logic [15:0]       reg_wdata_i,           // Write word
  input wire logic [15:0]       reg_rdata_o,           // Read word
  input wire logic              reg_rvalid_o,          // Read done
  input wire logic              conv_start_o,          // Start pulse
  input wire logic              conv_abort_o,          // Abort pulse
  input wire logic [2:0]        conv_chan_o,           // Input select
  input wire logic              conv_range_o,          // Range
  input wire logic              conv_done_i,           // Result pulse
  input wire logic              adc_power_o,           // Converter on
  input wire logic              ref_buf_on_o,          // Int. ref
  input wire logic [3:0]        dac_on_o,              // Output on
  input wire logic [3:0]        dac_sync_o,            // Sync mode
  input wire logic              result_ready_pin_oe_o, // Ready drive
  input wire logic              srst_busy_o            // Soft reset
);
  logic        wr_ok;
  logic        mode_q;
  logic [15:0] chan_q;
  logic [15:0] range_q;
  logic [15:0] wd_q;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  assign wr_ok = reg_wr_i && !srst_busy_o;
  // Shadows of the settings the sequencer must obey.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      chan_q  <= 16'h0000;
      range_q <= RANGE_RST;
      mode_q  <= 1'b1;
    end else if (srst_busy_o) begin
      chan_q  <= 16'h0000;
      range_q <= RANGE_RST;
      mode_q  <= 1'b1;
    end else if (wr_ok && reg_addr_i == A_CHAN_SEL) begin
      chan_q <= reg_wdata_i;
    end else if (wr_ok && reg_addr_i == A_RANGE_SEL) begin
      range_q <= reg_wdata_i;
    end else if (wr_ok && reg_addr_i == A_CONFIG) begin
      mode_q <= reg_wdata_i[CFG_MODE];
    end
  end
  always_ff @(posedge clk_i) begin
    wd_q <= reg_wdata_i;
  end
  id_read_a: assert property (reg_rd_i && !srst_busy_o &&
    reg_addr_i == A_IDENTITY |=> reg_rvalid_o && reg_rdata_o == PART_CODE)
    else $error("identity read gave a wrong answer");
  srst_block_a: assert property (reg_rd_i && srst_busy_o
    |=> !reg_rvalid_o) else $error("read answered during soft reset");
  key_start_a: assert property (wr_ok && reg_addr_i == A_SRST_KEY &&
    reg_wdata_i == SRST_KEY |=> srst_busy_o[*8])
    else $error("key write did not start soft reset");
  key_other_a: assert property (wr_ok && reg_addr_i == A_SRST_KEY &&
    reg_wdata_i != SRST_KEY |=> !srst_busy_o)
    else $error("non-key write started soft reset");
  power_bits_a: assert property (wr_ok &&
    reg_addr_i == A_POWER |=> {adc_power_o, ref_buf_on_o, dac_on_o} ==
    {wd_q[14], wd_q[13], wd_q[9], wd_q[10], wd_q[11], wd_q[12]})
    else $error("power outputs differ from written bits");
  sync_bits_a: assert property (wr_ok && reg_addr_i == A_UPD_MODE
    |=> dac_sync_o == wd_q[3:0]) else $error("update mode bits wrong");
  ready_clear_a: assert property (reg_rd_i && !srst_busy_o &&
    !mode_q && !conv_done_i && reg_addr_i >= A_RESULT0 &&
    reg_addr_i <= A_RESULT7 |=> !result_ready_pin_oe_o)
    else $error("result read did not clear ready");
  start_chan_a: assert property (conv_start_o && !$past(reg_wr_i)
    |-> chan_q[CHAN_POS[conv_chan_o]]) else $error("disabled input started");
  start_range_a: assert property (conv_start_o && !$past(reg_wr_i)
    |-> conv_range_o == range_q[RANGE_CH0 - conv_chan_o])
    else $error("range of started input wrong");
  cover property (conv_abort_o);
  cover property ($rose(result_ready_pin_oe_o));
  cover property ($rose(srst_busy_o));
endmodule

bind masc_top masc_props masc_props_inst (
  .clk_i, .rstn_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i,
  .reg_rdata_o, .reg_rvalid_o, .conv_start_o, .conv_abort_o, .conv_chan_o,
  .conv_range_o, .conv_done_i, .adc_power_o, .ref_buf_on_o, .dac_on_o,
  .dac_sync_o, .result_ready_pin_oe_o, .srst_busy_o
);

/* testbench/masc_top_bench.sv */
// Self-checking bench of the sequencer control, driven as the host would.
// Assumes the checker is bound to masc_top and the converter model answers.
`timescale 1ns/1ps
module masc_top_bench;
  import masc_pkg::*;
  logic              clk_i, rstn_i, reg_wr_i, reg_rd_i, reg_rvalid_o;
  logic [ADDR_W-1:0] reg_addr_i;
  logic [15:0]       reg_wdata_i, reg_rdata_o, rd_v;
  logic              conv_start_o, conv_abort_o, conv_range_o, conv_done_i;
  logic [2:0]        conv_chan_o;
  logic [RES_W-1:0]  conv_data_i;
  logic              adc_power_o, ref_buf_on_o, srst_busy_o;
  logic              result_ready_pin_o, result_ready_pin_oe_o;
  logic [3:0]        dac_on_o, dac_sync_o, lat;
  logic [3:0][RES_W-1:0] dac_code_o;
  int                err_total, tests_run, aborts, cyc, n, a;
  logic [2:0]        starts[$];
  localparam logic [6:0]  RA [7] = '{A_CHAN_SEL, A_RANGE_SEL, A_FORCE_CLR,
                                     A_UPD_MODE, A_POWER, A_IDENTITY, 7'h10};
  localparam logic [15:0] RV [7] = '{16'h0000, RANGE_RST, 16'h0000,
                                     16'h0000, 16'h0000, PART_CODE, 16'h0000};
  localparam logic [2:0]  CH [3] = '{3'h0, 3'h4, 3'h7};

  masc_top masc_top_inst (.clk_i, .rstn_i, .reg_wr_i, .reg_rd_i, .reg_addr_i,
    .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o, .conv_start_o, .conv_abort_o,
    .conv_chan_o, .conv_range_o, .conv_done_i, .conv_data_i, .adc_power_o,
    .ref_buf_on_o, .dac_on_o, .dac_code_o, .dac_sync_o, .result_ready_pin_o,
    .result_ready_pin_oe_o, .srst_busy_o);
  masc_conv_model masc_conv_model_inst (.clk_i, .rstn_i, .start_i(conv_start_o),
    .abort_i(conv_abort_o), .chan_i(conv_chan_o), .lat_i(lat),
    .done_o(conv_done_i), .data_o(conv_data_i));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (conv_start_o === 1'b1) starts.push_back(conv_chan_o);
    if (conv_abort_o === 1'b1) aborts++;
    if (cyc == 6000) begin
      err_total++;
      give_verdict();
    end
  end

  task automatic chk(input string nm, input logic [15:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [6:0] ad, input logic [15:0] d);
    @(negedge clk_i);
    reg_wr_i = 1'b1;
    reg_addr_i = ad;
    reg_wdata_i = d;
    @(negedge clk_i);
    reg_wr_i = 1'b0;
    @(negedge clk_i);
  endtask
  // A read that gets no answer yields all unknowns; only an all-unknown
  // expectation matches that.
  task automatic rd(input logic [6:0] ad);
    @(negedge clk_i);
    reg_rd_i = 1'b1;
    reg_addr_i = ad;
    @(negedge clk_i);
    reg_rd_i = 1'b0;
    rd_v = (reg_rvalid_o === 1'b1) ? reg_rdata_o : 16'hXXXX;
  endtask
  task automatic wait_starts(input int cnt);
    for (int k = 0; k < 400 && starts.size() < cnt; k++) @(negedge clk_i);
  endtask

  task automatic t_regs;
    wr(A_IDENTITY, 16'h0000);
    for (int i = 0; i < 7; i++) begin
      rd(RA[i]);
      chk("reset value", rd_v, RV[i]);
    end
    $display("test regs done");
  endtask
  task automatic t_dac;
    wr(A_DACDATA0, 16'h0123);
    wr(A_DACCLR0, 16'h03AB);
    wr(A_FORCE_CLR, 16'h0001);
    chk("dac0 forced", 16'(dac_code_o[0]), 16'h03AB);
    wr(A_FORCE_CLR, 16'h0000);
    chk("dac0 normal", 16'(dac_code_o[0]), 16'h0123);
    wr(A_UPD_MODE, 16'h0002);
    wr(A_DACDATA0 + 7'h1, 16'h00F0);
    chk("dac1 held", 16'(dac_code_o[1]), 16'h0000);
    wr(A_CONFIG, 16'h0800);
    chk("dac1 commit", 16'(dac_code_o[1]), 16'h00F0);
    wr(A_POWER, 16'h5400);
    chk("power", {10'h0, adc_power_o, ref_buf_on_o, dac_on_o}, 16'h0025);
    $display("test outputs done");
  endtask
  task automatic t_direct;
    lat = 4'h4;
    wr(A_RANGE_SEL, 16'h2C00);
    wr(A_CHAN_SEL, 16'h4120);
    n = starts.size();
    wr(A_CONFIG, 16'h1000);
    wait_starts(n + 3);
    // The host stays off the port while the pass converts.
    repeat (60) @(negedge clk_i);
    chk("one pass", 16'(starts.size() - n), 16'h0003);
    for (int i = 0; i < 3; i++) begin
      chk("order", 16'(starts[n+i]), 16'(CH[i]));
    end
    chk("ready pin", 16'(result_ready_pin_oe_o), 16'h0001);
    chk("pin level", 16'(result_ready_pin_o), 16'h0000);
    rd(A_CONFIG);
    chk("config", rd_v & 16'h3080, 16'h0080);
    for (int i = 0; i < 3; i++) begin
      rd(A_RESULT0 + 7'(CH[i]));
      chk("result", rd_v, {6'h0, CH[i], 7'h55});
    end
    chk("ready clear", 16'(result_ready_pin_oe_o), 16'h0000);
    $display("test direct done");
  endtask
  task automatic t_abort;
    lat = 4'hC;
    n = starts.size();
    a = aborts;
    wr(A_CONFIG, 16'h1000);
    wait_starts(n + 2);
    wr(A_CONFIG, 16'h1000);
    wait_starts(n + 3);
    chk("abort", 16'(aborts - a), 16'h0001);
    chk("restart", 16'(starts[n+2]), 16'h0000);
    repeat (80) @(negedge clk_i);
    $display("test abort done");
  endtask
  task automatic t_auto;
    lat = 4'h8;
    n = starts.size();
    // Mode first, trigger second: in one write with the mode change the trigger would be dropped.
    wr(A_CONFIG, 16'h2000);
    wr(A_CONFIG, 16'h3000);
    wait_starts(n + 7);
    for (int i = 0; i < 7; i++) begin
      chk("loop", 16'(starts[n+i]), 16'(CH[i%3]));
    end
    a = aborts;
    wr(A_CONFIG, 16'h0000);
    repeat (60) @(negedge clk_i);
    n = starts.size();
    chk("mode stop", 16'(aborts - a), 16'h0001);
    wr(A_CONFIG, 16'h3000);
    repeat (80) @(negedge clk_i);
    chk("trig and mode", 16'(starts.size() - n), 16'h0000);
    $display("test auto done");
  endtask
  task automatic t_srst;
    wr(A_SRST_KEY, 16'h1234);
    chk("no reset", 16'(srst_busy_o), 16'h0000);
    wr(A_SRST_KEY, SRST_KEY);
    chk("reset busy", 16'(srst_busy_o), 16'h0001);
    rd(A_IDENTITY);
    chk("refused", rd_v, 16'hXXXX);
    // The host keeps quiet until the reset has run out.
    for (int k = 0; k < 1000 && srst_busy_o !== 1'b0; k++) begin
      @(negedge clk_i);
    end
    rd(A_RANGE_SEL);
    chk("range again", rd_v, RANGE_RST);
    $display("test soft reset done");
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    rstn_i = 1'b0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_addr_i = '0;
    reg_wdata_i = 16'h0000;
    lat = 4'h4;
    repeat (20) @(negedge clk_i);
    rstn_i = 1'b1;
    t_regs();
    t_dac();
    t_direct();
    t_abort();
    t_auto();
    t_srst();
    give_verdict();
  end
endmodule
